/* File: hw/rfw_top.sv */
// rx fifo low watermark, overflow drop counters, soft reset and overflow events
//
// Behaviour
// [R1] low threshold counts 8-byte units, reset 0x072
// [R2] fill below threshold releases port 3 flow control
// [R3] software keeps low threshold below high threshold
// [R4] threshold in bits 11:0, upper bits read zero
// [R5] per-port 32-bit counters of full/reset drops
// [R6] drop counters clear when read
// [R7] soft reset bit n serves port n
// [R8] write 1 holds reset, 0 releases; reset 0
// [R9] overflow sets per-port event bit, clear on read
// [R10] one port's soft reset leaves others alone
`timescale 1ns/1ns
`include "rfw_map.svh"
module rfw_top (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`RFW_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // receive fifo side, start and full one bit per port, fill and request for port 3 only
    input  wire logic [3:0]               frame_start,
    input  wire logic [3:0]               fifo_full,
    input  wire logic [`RFW_FILL_W-1:0]   fill_bytes_p3,
    input  wire logic                     flow_ctrl_assert_p3,
    // control outputs
    output logic [3:0]                    fifo_soft_reset,
    output logic                          flow_ctrl_active_p3
);
    // apb access decode
    logic                  acc;
    logic                  wr;
    logic                  rd;
    logic [`RFW_IDX_W-1:0] idx;
    logic                  aligned;
    logic                  hit_thr;
    logic                  hit_rst;
    logic                  hit_evt;
    logic [3:0]            hit_cnt;
    logic                  mapped;

    // word index is byte address over four; low bits must be zero
    always_comb begin
        acc     = psel && penable;
        idx     = paddr[`RFW_ADDR_W-1:2];
        aligned = (paddr[1:0] == 2'h0);
        hit_thr = aligned && (idx == `RFW_IDX_LOW_THR_P3);
        hit_rst = aligned && (idx == `RFW_IDX_SOFT_RST);
        hit_evt = aligned && (idx == `RFW_IDX_OVFL_EVT);
        hit_cnt[0] = aligned && (idx == `RFW_IDX_DROP_P0);
        hit_cnt[1] = aligned && (idx == `RFW_IDX_DROP_P1);
        hit_cnt[2] = aligned && (idx == `RFW_IDX_DROP_P2);
        hit_cnt[3] = aligned && (idx == `RFW_IDX_DROP_P3);
        mapped  = hit_thr || hit_rst || hit_evt || (|hit_cnt);
        wr      = acc && pwrite;
        rd      = acc && !pwrite;
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // control registers
    rfw_pkg::rfw_thr_t      thr_q;
    rfw_pkg::rfw_thr_t      thr_d;
    rfw_pkg::rfw_port_vec_t srst_q;
    rfw_pkg::rfw_port_vec_t srst_d;

    // only the low field is writable; upper bits are dropped
    always_comb begin
        thr_d  = thr_q;
        srst_d = srst_q;
        if (wr && hit_thr) begin
            thr_d = pwdata[`RFW_THR_W-1:0];                     // [R4]
        end
        if (wr && hit_rst) begin
            srst_d = pwdata[`RFW_NPORTS-1:0];                   // [R7] [R8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q  <= `RFW_THR_RESET;                           // [R1]
            srst_q <= 4'h0;                                     // [R8]
        end else begin
            thr_q  <= thr_d;
            srst_q <= srst_d;
        end
    end

    // each port's reset line comes from its own bit only
    assign fifo_soft_reset = srst_q;                            // [R10]

    // flow control for port 3, threshold scaled to bytes
    logic [`RFW_FILL_W-1:0] thr_bytes;
    logic                   below_low;
    logic                   fc_q;
    logic                   fc_d;

    // hysteresis: the high-side request sets it, dropping below low clears
    always_comb begin
        thr_bytes = {1'b0, thr_q, 3'h0};                        // [R1]
        below_low = (fill_bytes_p3 < thr_bytes);
        fc_d      = fc_q;
        if (srst_q[3] || below_low) begin
            fc_d = 1'b0;                                        // [R2]
        end else if (flow_ctrl_assert_p3) begin
            fc_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_q <= 1'b0;
        end else begin
            fc_q <= fc_d;
        end
    end

    assign flow_ctrl_active_p3 = fc_q;

    // a frame starting into a full or reset fifo is lost
    logic [3:0]  drop_evt;
    logic [3:0]  ovfl_evt;
    logic [31:0] cnt [4];

    always_comb begin
        ovfl_evt = frame_start & fifo_full & ~srst_q;           // [R9]
        drop_evt = frame_start & (fifo_full | srst_q);          // [R5] [R10]
    end

    // counters are one small module per port
    for (genvar p = 0; p < `RFW_NPORTS; p++) begin : g_cnt
        rfw_drop_counter u_cnt (
            .pclk    (pclk),
            .presetn (presetn),
            .drop_evt(drop_evt[p]),
            .rd_clr  (rd && hit_cnt[p]),                         // [R6]
            .count_q (cnt[p])
        );
    end

    // overflow event status, set wins over the read clear
    rfw_pkg::rfw_port_vec_t evt_q;
    rfw_pkg::rfw_port_vec_t evt_d;

    always_comb begin
        evt_d = evt_q;
        if (rd && hit_evt) begin
            evt_d = 4'h0;                                       // [R9]
        end
        evt_d = evt_d | ovfl_evt;                               // [R9]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= 4'h0;
        end else begin
            evt_q <= evt_d;
        end
    end

    // read mux, reserved bits zero
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        rdata_d = rdata_q;
        if (psel && !penable && !pwrite) begin
            rdata_d = 32'h00000000;
            if (hit_thr) rdata_d = {20'h00000, thr_q};          // [R4]
            if (hit_rst) rdata_d = {28'h0000000, srst_q};       // [R7]
            if (hit_evt) rdata_d = {28'h0000000, evt_q};
            for (int i = 0; i < `RFW_NPORTS; i++) begin
                if (hit_cnt[i]) rdata_d = cnt[i];
            end
        end
    end

    // captured in setup; clears happen in the access cycle, so a drop
    // landing in the setup cycle misses the read data and is then cleared, so it is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
endmodule

/* File: hw/rfw_map.svh */
// register offsets, field positions and reset values for the rx fifo watermark/drop block
`ifndef RFW_MAP_SVH
`define RFW_MAP_SVH

// printed register indices (not all multiples of four: byte address = index * 4)
`define RFW_IDX_LOW_THR_P3    12'h58D
`define RFW_IDX_DROP_P0       12'h594
`define RFW_IDX_DROP_P1       12'h595
`define RFW_IDX_DROP_P2       12'h596
`define RFW_IDX_DROP_P3       12'h597
`define RFW_IDX_SOFT_RST      12'h59E
`define RFW_IDX_OVFL_EVT      12'h5A0

// address width of the apb byte address
`define RFW_ADDR_W            14
`define RFW_IDX_W             12

// field layout
`define RFW_THR_W             12
`define RFW_THR_RESET         12'h072
`define RFW_NPORTS            4
`define RFW_CNT_W             32
`define RFW_FILL_W            16
`define RFW_UNIT_SHIFT        3

`endif

/* File: hw/rfw_pkg.sv */
// types shared by the rx fifo watermark/drop block
package rfw_pkg;
    typedef logic [11:0] rfw_thr_t;
    typedef logic [31:0] rfw_word_t;
    typedef logic [3:0]  rfw_port_vec_t;
endpackage

/* File: hw/rfw_drop_counter.sv */
// one per-port clear-on-read drop counter
`timescale 1ns/1ns
module rfw_drop_counter (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // events and control
    input  wire logic        drop_evt,
    input  wire logic        rd_clr,
    // count out
    output logic [31:0]      count_q
);
    logic [31:0] count_d;

    // a drop in the read cycle survives as count 1, so that drop is not lost
    always_comb begin
        count_d = count_q;
        if (rd_clr) begin
            count_d = drop_evt ? 32'h00000001 : 32'h00000000;   // [R6]
        end else if (drop_evt && count_q != 32'hFFFFFFFF) begin
            count_d = count_q + 32'h00000001;                   // [R5]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h00000000;                            // [R5]
        end else begin
            count_q <= count_d;
        end
    end
endmodule

/* File: test/rfw_checker.sv */
// port assertions for the rx fifo watermark block
`timescale 1ns/1ns
`include "rfw_map.svh"
module rfw_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // fifo side
    input wire logic [3:0]  frame_start,
    input wire logic [15:0] fill_bytes_p3,
    input wire logic        flow_ctrl_assert_p3,
    input wire logic [3:0]  fifo_soft_reset,
    input wire logic        flow_ctrl_active_p3
);
    localparam logic [13:0] A_THR = {`RFW_IDX_LOW_THR_P3, 2'h0};
    localparam logic [13:0] A_D0  = {`RFW_IDX_DROP_P0, 2'h0};
    localparam logic [13:0] A_SR  = {`RFW_IDX_SOFT_RST, 2'h0};
    localparam logic [13:0] A_EV  = {`RFW_IDX_OVFL_EVT, 2'h0};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // read setup and write access qualifiers
    wire rs = psel && !penable && !pwrite;
    wire wa = psel && penable && pwrite;
    AST_SR_WR: assert property (wa && paddr == A_SR
        |=> fifo_soft_reset == $past(pwdata[3:0])) else $error("soft reset write lost");
    AST_SR_HOLD: assert property (!(wa && paddr == A_SR)
        |=> $stable(fifo_soft_reset)) else $error("soft reset moved alone");
    AST_THR_RD: assert property (rs && paddr == A_THR
        |=> prdata[31:12] == 20'h00000) else $error("threshold upper bits set");
    AST_SR_RD: assert property (rs && paddr == A_SR
        |=> prdata[31:4] == 28'h0000000) else $error("soft reset upper bits set");
    AST_EV_RD: assert property (rs && paddr == A_EV
        |=> prdata[31:4] == 28'h0000000) else $error("event upper bits set");
    // a port 0 read with no drop in its access cycle or the idle gap leaves zero for the next read
    AST_RC: assert property ((psel && penable && !pwrite && paddr == A_D0 && !frame_start[0])
        ##1 (!psel && !frame_start[0]) ##1 (rs && paddr == A_D0)
        |=> prdata == 32'h00000000) else $error("counter not cleared by read");
    AST_FC_SR: assert property (fifo_soft_reset[3]
        |=> !flow_ctrl_active_p3) else $error("flow control kept in reset");
    // fill at or above the largest threshold can never be below it
    AST_FC_SET: assert property (flow_ctrl_assert_p3 && !fifo_soft_reset[3]
        && fill_bytes_p3 >= 16'h7FF8 |=> flow_ctrl_active_p3) else $error("flow control not set");
endmodule
bind rfw_top rfw_checker u_rfw_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .frame_start, .fill_bytes_p3, .flow_ctrl_assert_p3, .fifo_soft_reset,
    .flow_ctrl_active_p3);

/* File: test/rfw_top_tb.sv */
// self-checking bench for the rx fifo watermark block
`timescale 1ns/1ns
`include "rfw_map.svh"
module rfw_top_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  frame_start = 4'h0;
    logic [3:0]  fifo_full = 4'h0;
    logic [15:0] fill_bytes_p3 = 16'h0000;
    logic        flow_ctrl_assert_p3 = 1'b0;
    logic [3:0]  fifo_soft_reset;
    logic        flow_ctrl_active_p3;
    logic [31:0] r;
    logic        e;
    int          fails = 0;
    int          checked = 0;
    localparam logic [11:0] THR = `RFW_IDX_LOW_THR_P3;
    localparam logic [11:0] D0 = `RFW_IDX_DROP_P0;
    localparam logic [11:0] SR = `RFW_IDX_SOFT_RST;
    localparam logic [11:0] EV = `RFW_IDX_OVFL_EVT;
    // free-running 125 MHz clock
    always #4 pclk = ~pclk;
    rfw_top u_rfw_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .frame_start, .fifo_full, .fill_bytes_p3, .flow_ctrl_assert_p3,
        .fifo_soft_reset, .flow_ctrl_active_p3);
    task stop_test;
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH %0t seen %h want %h", $time, s, x);
        end
    endtask
    // one apb transfer, byte address is index times four
    task xf(input logic w, input logic [11:0] i, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            stop_test;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [11:0] i, input logic [31:0] x);
        xf(1'b0, i, 32'h00000000);
        chk(r, x);
    endtask
    task pulse(input logic [3:0] m);
        @(posedge pclk);
        frame_start <= m;
        @(posedge pclk);
        frame_start <= 4'h0;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk(THR, 32'h00000072);
        rchk(SR, 32'h00000000);
        xf(1'b1, THR, 32'hFFFFFFFF);
        rchk(THR, 32'h00000FFF);
        // port n sees n+1 frames while full
        fifo_full <= 4'hF;
        for (int p = 0; p < 4; p++) repeat (p + 1) pulse(4'(1 << p));
        fifo_full <= 4'h0;
        for (int p = 0; p < 4; p++) begin
            rchk(D0 + 12'(p), 32'(p + 1));
            rchk(D0 + 12'(p), 32'h00000000);
        end
        rchk(EV, 32'h0000000F);
        rchk(EV, 32'h00000000);
        // ports 2 and 3 held in reset, a full frame on every port
        xf(1'b1, SR, 32'hFFFFFFFC);
        #1 chk({28'h0000000, fifo_soft_reset}, 32'h0000000C);
        rchk(SR, 32'h0000000C);
        fifo_full <= 4'hF;
        pulse(4'hF);
        fifo_full <= 4'h0;
        for (int p = 0; p < 4; p++) rchk(D0 + 12'(p), 32'h00000001);
        rchk(EV, 32'h00000003);
        flow_ctrl_assert_p3 <= 1'b1;
        fill_bytes_p3 <= 16'h8000;
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, flow_ctrl_active_p3}, 32'h00000000);
        xf(1'b1, SR, 32'h00000000);
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, flow_ctrl_active_p3}, 32'h00000001);
        // threshold of 2 units means 16 bytes
        xf(1'b1, THR, 32'h00000002);
        flow_ctrl_assert_p3 <= 1'b0;
        fill_bytes_p3 <= 16'h0010;
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, flow_ctrl_active_p3}, 32'h00000001);
        @(posedge pclk);
        fill_bytes_p3 <= 16'h000F;
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, flow_ctrl_active_p3}, 32'h00000000);
        // unmapped address is refused
        xf(1'b0, 12'h001, 32'h00000000);
        chk({31'h0, e}, 32'h00000001);
        stop_test;
    end
endmodule
